// ===== hdl/cocr_top.sv
// clock output control register bank: smbus block writes set output
// enables, stop selects, delay and edge controls; clocks are gated here
// assumes source clocks and smbus pins are synchronous to clk
//
// What this block does
// - byte 2 bits 6..0 gate bus clocks
// - byte 3 bit 7 enables display clock
// - byte 3 bit 6 enables usb clock
// - byte 3 bits 5..3 let stop halt
// - byte 3 bits 2..0 enable free clocks
// - byte 4 bits 5,4 enable 66/video
// - byte 4 bit 3 enables sixth 66
// - byte 4 bits 2..0 enable buffered
// - byte 5 bits 5,4 buffered delay
// - byte 5 bits 3,2 display edge rate
// - byte 5 bits 1,0 usb edge rate
// - byte 6 fixed revision and vendor
// - only address D2h, command 00h
// - count 1..32, bytes in order
// - valid after count byte acknowledged
`timescale 1ns/10ps
module cocr_top #(
    parameter logic [3:0] REV_CODE    = 4'h3, // arbitrary value
    parameter logic [3:0] VENDOR_CODE = 4'h5  // arbitrary value
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // smbus pins
    input  wire logic       smb_scl,
    input  wire logic       smb_sda_in,
    output logic            smb_sda_out,
    output logic            smb_sda_oe,
    // stop pin
    input  wire logic       bus_stop_n,
    // source clocks
    input  wire logic [6:0] bus_src,
    input  wire logic [2:0] free_src,
    input  wire logic       display_48m_src,
    input  wire logic       usb_48m_src,
    input  wire logic       sixtysix_src,
    input  wire logic       video_channel_src,
    input  wire logic       sixtysix5_src,
    input  wire logic [2:0] buffered_src,
    // gated clocks
    output logic [6:0]      bus_clk_out,
    output logic [2:0]      free_clk_out,
    output logic            display_48m_clock,
    output logic            usb_48m_clock,
    output logic            sixtysix_mhz_output,
    output logic            video_channel_clock,
    output logic            sixtysix_mhz_output5,
    output logic [2:0]      buffered_sixtysix_output,
    // analog controls and identity
    output logic [1:0]      buf_delay_ctl,
    output logic [1:0]      display_edge_ctl,
    output logic [1:0]      usb_edge_ctl,
    output logic [7:0]      vendor_revision_id
);

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_ADDR  = 6'b000010,
        ST_CMD   = 6'b000100,
        ST_COUNT = 6'b001000,
        ST_DATA  = 6'b010000,
        ST_SKIP  = 6'b100000
    } cocr_ctl_state_t;

    typedef struct packed {
        cocr_ctl_state_t state;
        logic            ack;
        logic            valid;
        logic [5:0]      count;
        logic [5:0]      idx;
        logic [7:0]      bus_en;
        logic [7:0]      free_ctl;
        logic [7:0]      en66;
        logic [7:0]      dly;
        logic [7:0]      id;
    } cocr_ctl_st_t;

    cocr_ctl_st_t                 s_q;
    cocr_ctl_st_t                 s_d;
    logic                         start_p;
    logic                         stop_p;
    logic                         byte_p;
    logic [7:0]                   byte_val;
    logic                         ack_done_p;
    logic [cocr_pkg::NUM_CLK-1:0] en_vec;
    logic [cocr_pkg::NUM_CLK-1:0] src_vec;
    logic [cocr_pkg::NUM_CLK-1:0] gated;
    logic [2:0]                   free_halt;
    logic                         take_data;

    // only writable bits move
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction : merge

    // ==========================================
    // serial receiver
    cocr_smbus_rx u_rx (
        .clk        (clk),
        .reset      (reset),
        .scl        (smb_scl),
        .sda_in     (smb_sda_in),
        .sda_out    (smb_sda_out),
        .sda_oe     (smb_sda_oe),
        .ack_en     (s_q.ack),
        .start_p    (start_p),
        .stop_p     (stop_p),
        .byte_p     (byte_p),
        .byte_val   (byte_val),
        .ack_done_p (ack_done_p)
    );

    assign take_data = byte_p && (s_q.state == ST_DATA) && s_q.valid && (s_q.idx < s_q.count);

    // ==========================================
    // transfer sequencer and registers
    always_comb begin
        s_d = s_q;
        if (start_p) begin
            s_d.state = ST_ADDR;
            s_d.valid = 1'b0;
            s_d.ack   = 1'b0;
        end else if (stop_p) begin
            s_d.state = ST_IDLE;
            s_d.valid = 1'b0;
            s_d.ack   = 1'b0;
        end else if (byte_p) begin
            s_d.ack   = 1'b0;
            s_d.state = ST_SKIP;
            case (s_q.state)
                ST_ADDR: begin
                    if (byte_val == cocr_pkg::SLAVE_ADDR) begin
                        s_d.ack   = 1'b1;
                        s_d.state = ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (byte_val == cocr_pkg::CMD_CODE) begin
                        s_d.ack   = 1'b1;
                        s_d.state = ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (byte_val >= cocr_pkg::COUNT_MIN && byte_val <= cocr_pkg::COUNT_MAX) begin
                        s_d.ack   = 1'b1;
                        s_d.count = byte_val[5:0];
                        s_d.idx   = '0;
                        s_d.state = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (take_data) begin
                        s_d.ack   = 1'b1;
                        s_d.idx   = s_q.idx + 6'h01;
                        s_d.state = ST_DATA;
                        if (s_q.idx == cocr_pkg::OFS_BUS_EN) begin
                            s_d.bus_en = merge(s_q.bus_en, byte_val, cocr_pkg::WMASK_BUS);
                        end
                        if (s_q.idx == cocr_pkg::OFS_FREE) begin
                            s_d.free_ctl = merge(s_q.free_ctl, byte_val, cocr_pkg::WMASK_FREE);
                        end
                        if (s_q.idx == cocr_pkg::OFS_66_EN) begin
                            s_d.en66 = merge(s_q.en66, byte_val, cocr_pkg::WMASK_66);
                        end
                        if (s_q.idx == cocr_pkg::OFS_DELAY) begin
                            s_d.dly = merge(s_q.dly, byte_val, cocr_pkg::WMASK_DELAY);
                        end
                    end
                end
                default: begin
                    s_d.ack = 1'b0;
                end
            endcase
        end else if (ack_done_p && s_q.state == ST_DATA && !s_q.valid) begin
            s_d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '{state:    ST_IDLE,
                     ack:      1'b0,
                     valid:    1'b0,
                     count:    '0,
                     idx:      '0,
                     bus_en:   cocr_pkg::RST_BUS_EN,
                     free_ctl: cocr_pkg::RST_FREE,
                     en66:     cocr_pkg::RST_66_EN,
                     dly:      cocr_pkg::RST_DELAY,
                     id:       {REV_CODE, VENDOR_CODE}};
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // enables toward the gates
    // selected free clocks follow stop
    assign free_halt = s_q.free_ctl[cocr_pkg::FREE_STOP_LSB +: 3] & {3{~bus_stop_n}};

    // stoppable clocks always obey the stop pin
    assign en_vec = {s_q.en66[cocr_pkg::BUF_EN_LSB +: 3],
                     s_q.en66[cocr_pkg::BIT_66_5_EN],
                     s_q.en66[cocr_pkg::BIT_VCH_EN],
                     s_q.en66[cocr_pkg::BIT_66_0_EN],
                     s_q.free_ctl[cocr_pkg::BIT_USB_EN],
                     s_q.free_ctl[cocr_pkg::BIT_DOT_EN],
                     s_q.free_ctl[cocr_pkg::FREE_EN_LSB +: 3] & ~free_halt,
                     s_q.bus_en[6:0] & {7{bus_stop_n}}};

    assign src_vec = {buffered_src, sixtysix5_src, video_channel_src, sixtysix_src,
                      usb_48m_src, display_48m_src, free_src, bus_src};

    cocr_clk_gate #(
        .N (cocr_pkg::NUM_CLK)
    ) u_gate (
        .clk   (clk),
        .reset (reset),
        .src   (src_vec),
        .en    (en_vec),
        .gated (gated)
    );

    assign bus_clk_out              = gated[cocr_pkg::IDX_BUS +: 7];
    assign free_clk_out             = gated[cocr_pkg::IDX_FREE +: 3];
    assign display_48m_clock        = gated[cocr_pkg::IDX_DOT];
    assign usb_48m_clock            = gated[cocr_pkg::IDX_USB];
    assign sixtysix_mhz_output      = gated[cocr_pkg::IDX_66_0];
    assign video_channel_clock      = gated[cocr_pkg::IDX_VCH];
    assign sixtysix_mhz_output5     = gated[cocr_pkg::IDX_66_5];
    assign buffered_sixtysix_output = gated[cocr_pkg::IDX_BUF +: 3];

    assign buf_delay_ctl      = s_q.dly[cocr_pkg::DELAY_LSB +: 2];
    assign display_edge_ctl   = s_q.dly[cocr_pkg::DOT_EDGE_LSB +: 2];
    assign usb_edge_ctl       = s_q.dly[cocr_pkg::USB_EDGE_LSB +: 2];
    assign vendor_revision_id = s_q.id;

    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_ADDR_FILTER: assert property (
        byte_p && s_q.state == ST_ADDR && byte_val != cocr_pkg::SLAVE_ADDR
        |=> !s_q.ack && s_q.state == ST_SKIP)
        else $error("foreign address acknowledged");
    AST_CMD_FILTER: assert property (
        byte_p && s_q.state == ST_CMD && byte_val != cocr_pkg::CMD_CODE |=> !s_q.ack)
        else $error("foreign command acknowledged");
    AST_COUNT_RANGE: assert property (
        byte_p && s_q.state == ST_COUNT && (byte_val == 8'h00 || byte_val > 8'h20)
        |=> !s_q.ack ##1 !s_q.valid)
        else $error("bad byte count accepted");
    AST_WRITE_NEEDS_VALID: assert property (
        $changed(s_q.bus_en) || $changed(s_q.free_ctl) || $changed(s_q.en66)
        || $changed(s_q.dly) |-> $past(s_q.valid))
        else $error("register written before count acknowledge");
    AST_BUS_WRITE: assert property (
        take_data && s_q.idx == 6'h02 |=> s_q.bus_en == ($past(byte_val) & 8'h7F))
        else $error("bus clock enables not written");
    AST_FREE_WRITE: assert property (
        take_data && s_q.idx == 6'h03 |=> s_q.free_ctl == $past(byte_val))
        else $error("free clock control not written");
    AST_66_WRITE: assert property (
        take_data && s_q.idx == 6'h04 |=> ##1 s_q.en66 == ($past(byte_val, 2) & 8'h3F))
        else $error("66 MHz enables not written");
    AST_DLY_WRITE: assert property (
        take_data && s_q.idx == 6'h05 |=> buf_delay_ctl == $past(byte_val[5:4])
        && usb_edge_ctl == $past(byte_val[1:0]))
        else $error("delay and edge controls not written");
    AST_ID_FIXED: assert property ($stable(vendor_revision_id))
        else $error("identity byte changed");
    AST_RSVD_ZERO: assert property (
        !s_q.bus_en[7] && s_q.en66[7:6] == 2'b00 && s_q.dly[7:6] == 2'b00)
        else $error("reserved bit set");
    AST_FREE_STOP: assert property (
        !bus_stop_n && s_q.free_ctl[3] && !free_src[0] ##1 !bus_stop_n && s_q.free_ctl[3]
        |=> !free_clk_out[0])
        else $error("selected free clock not halted by stop");
    AST_DOT_OFF: assert property (
        !s_q.free_ctl[7] && !display_48m_src ##1 !s_q.free_ctl[7] |=> ##1 !display_48m_clock)
        else $error("disabled display clock toggles");

    COV_VALID_TRANSFER: cover property (ack_done_p && s_q.state == ST_DATA && !s_q.valid);
    COV_BUS_WRITE: cover property (take_data && s_q.idx == cocr_pkg::OFS_BUS_EN);
    COV_DELAY_WRITE: cover property (take_data && s_q.idx == cocr_pkg::OFS_DELAY);
    COV_FREE_HALT: cover property (free_halt != 3'b000);

endmodule : cocr_top

// ===== shared/cocr_pkg.sv
// constants shared by the clock output control register bank
// assumes an smbus host that writes block transfers only
package cocr_pkg;

    // ==========================================
    // serial protocol
    localparam logic [7:0] SLAVE_ADDR  = 8'hD2;
    localparam logic [7:0] CMD_CODE    = 8'h00;
    localparam logic [7:0] COUNT_MIN   = 8'h01;
    localparam logic [7:0] COUNT_MAX   = 8'h20;
    localparam int         IDX_W       = 6;

    // ==========================================
    // byte offsets within a block write
    localparam logic [5:0] OFS_BUS_EN  = 6'h02;
    localparam logic [5:0] OFS_FREE    = 6'h03;
    localparam logic [5:0] OFS_66_EN   = 6'h04;
    localparam logic [5:0] OFS_DELAY   = 6'h05;
    localparam logic [5:0] OFS_ID      = 6'h06;

    // ==========================================
    // values after reset and writable bits
    localparam logic [7:0] RST_BUS_EN  = 8'h7F;
    localparam logic [7:0] RST_FREE    = 8'hC7;
    localparam logic [7:0] RST_66_EN   = 8'h3F;
    localparam logic [7:0] RST_DELAY   = 8'h00;
    localparam logic [7:0] WMASK_BUS   = 8'h7F;
    localparam logic [7:0] WMASK_FREE  = 8'hFF;
    localparam logic [7:0] WMASK_66    = 8'h3F;
    localparam logic [7:0] WMASK_DELAY = 8'h3F;

    // ==========================================
    // field positions
    localparam int BIT_DOT_EN    = 7;
    localparam int BIT_USB_EN    = 6;
    localparam int FREE_STOP_LSB = 3;
    localparam int FREE_EN_LSB   = 0;
    localparam int BIT_66_0_EN   = 5;
    localparam int BIT_VCH_EN    = 4;
    localparam int BIT_66_5_EN   = 3;
    localparam int BUF_EN_LSB    = 0;
    localparam int DELAY_LSB     = 4;
    localparam int DOT_EDGE_LSB  = 2;
    localparam int USB_EDGE_LSB  = 0;

    // ==========================================
    // gated clock vector layout
    localparam int NUM_CLK  = 18;
    localparam int IDX_BUS  = 0;
    localparam int IDX_FREE = 7;
    localparam int IDX_DOT  = 10;
    localparam int IDX_USB  = 11;
    localparam int IDX_66_0 = 12;
    localparam int IDX_VCH  = 13;
    localparam int IDX_66_5 = 14;
    localparam int IDX_BUF  = 15;

endpackage : cocr_pkg

// ===== hdl/cocr_clk_gate.sv
// glitch-free gating of a vector of sampled source clocks
// assumes sources are sampled synchronously to clk
`timescale 1ns/10ps
module cocr_clk_gate #(
    parameter int N = 18
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // sources and wanted enables
    input  wire logic [N-1:0] src,
    input  wire logic [N-1:0] en,
    // gated clocks
    output logic [N-1:0]      gated
);

    typedef struct packed {
        logic [N-1:0] en;
        logic [N-1:0] out;
    } cocr_gate_st_t;

    cocr_gate_st_t s_q;
    cocr_gate_st_t s_d;

    // ==========================================
    // gating
    always_comb begin
        s_d = s_q;
        s_d.en  = (s_q.en & src) | (en & ~src);
        s_d.out = src & s_d.en;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '{en: '1, out: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign gated = s_q.out;

    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_GATE_NO_TRUNC: assert property (((s_q.en ^ $past(s_q.en)) & $past(src)) == '0)
        else $error("enable changed while source was high");
    // off for two cycles, source low at the first: output must rest low
    AST_GATE_LOW_WHEN_OFF: assert property (
        !$past(reset, 2) |-> (gated & ~$past(en) & ~$past(en, 2) & ~$past(src, 2)) == '0)
        else $error("disabled clock output is not low");

endmodule : cocr_clk_gate

// ===== hdl/cocr_smbus_rx.sv
// smbus bit level receiver: start, stop, byte shift and ack drive
// assumes scl and sda are synchronous to clk, each phase two cycles or more
`timescale 1ns/10ps
module cocr_smbus_rx (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // smbus pins
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // byte side
    input  wire logic       ack_en,
    output logic            start_p,
    output logic            stop_p,
    output logic            byte_p,
    output logic [7:0]      byte_val,
    output logic            ack_done_p
);

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_BITS = 3'b010,
        RX_ACK  = 3'b100
    } cocr_rx_state_t;

    typedef struct packed {
        cocr_rx_state_t state;
        logic           scl_p;
        logic           sda_p;
        logic [7:0]     sh;
        logic [3:0]     cnt;
        logic           acking;
        logic           oe;
        logic           start;
        logic           stop;
        logic           bytev;
        logic           ackd;
    } cocr_rx_st_t;

    cocr_rx_st_t s_q;
    cocr_rx_st_t s_d;
    logic        rise;
    logic        fall;

    assign rise = scl & ~s_q.scl_p;
    assign fall = ~scl & s_q.scl_p;

    // ==========================================
    // bit engine
    always_comb begin
        s_d       = s_q;
        s_d.scl_p = scl;
        s_d.sda_p = sda_in;
        s_d.start = 1'b0;
        s_d.stop  = 1'b0;
        s_d.bytev = 1'b0;
        s_d.ackd  = 1'b0;
        if (scl && s_q.scl_p && s_q.sda_p && !sda_in) begin
            s_d.state = RX_BITS;
            s_d.cnt   = 4'h0;
            s_d.oe    = 1'b0;
            s_d.start = 1'b1;
        end else if (scl && s_q.scl_p && !s_q.sda_p && sda_in) begin
            s_d.state = RX_IDLE;
            s_d.oe    = 1'b0;
            s_d.stop  = 1'b1;
        end else begin
            case (s_q.state)
                RX_IDLE: begin
                    s_d.oe = 1'b0;
                end
                RX_BITS: begin
                    if (rise) begin
                        s_d.sh  = {s_q.sh[6:0], sda_in};
                        s_d.cnt = s_q.cnt + 4'h1;
                        if (s_q.cnt == 4'h7) begin
                            s_d.bytev  = 1'b1;
                            s_d.acking = 1'b0;
                            s_d.state  = RX_ACK;
                        end
                    end
                end
                RX_ACK: begin
                    if (fall && !s_q.acking) begin
                        s_d.oe     = ack_en;
                        s_d.acking = 1'b1;
                    end else if (rise && s_q.acking) begin
                        s_d.ackd = s_q.oe;
                    end else if (fall && s_q.acking) begin
                        s_d.oe    = 1'b0;
                        s_d.cnt   = 4'h0;
                        s_d.state = RX_BITS;
                    end
                end
                default: begin
                    s_d.state = RX_IDLE;
                    s_d.oe    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '{state: RX_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_out    = 1'b0 & s_q.oe;
    assign sda_oe     = s_q.oe;
    assign start_p    = s_q.start;
    assign stop_p     = s_q.stop;
    assign byte_p     = s_q.bytev;
    assign byte_val   = s_q.sh;
    assign ack_done_p = s_q.ackd;

endmodule : cocr_smbus_rx

// ===== test/cocr_smb_host.sv
// smbus host model: block writes, four clk per scl phase
// assumes sda is the wired level with a pull-up
`timescale 1ns/10ps
module cocr_smb_host (
    // clock and bus
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // ==========================================
    // start, sda falls with scl high
    task automatic start;
        sda_low = 1'b1;
        cyc(4);
        scl = 1'b0;
    endtask : start
    task automatic put_byte(input logic [7:0] v, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_low = (i > 0) ? ~v[i-1] : 1'b0;
            cyc(4);
            scl = 1'b1;
            cyc(2);
            ack = ~sda;
            cyc(2);
            scl = 1'b0;
        end
    endtask : put_byte
    task automatic stop;
        sda_low = 1'b1;
        cyc(4);
        scl = 1'b1;
        cyc(4);
        sda_low = 1'b0;
        cyc(4);
    endtask : stop
endmodule : cocr_smb_host

// ===== test/testbench.sv
// bench for the clock output bank: block writes via the host model,
// gated outputs and controls compared with a register model
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0, reset = 1'b1, tog = 1'b0, stop_n = 1'b1;
    logic scl, sda_low, sda_oe, sda_out, dot_o, usb_o, s66_o, vch_o, s665_o;
    logic [6:0] bus_o;
    logic [2:0] free_o, buf_o;
    logic [1:0] dly, ed_d, ed_u;
    logic [7:0] id;
    logic [7:0] rg [2:5];
    logic [7:0] wm [2:5] = '{8'h7F, 8'hFF, 8'h3F, 8'h3F};
    int n_errors = 0, checked = 0;
    // device drive value counts, so a wrong level breaks the acks
    wire logic sda = ~(sda_low | (sda_oe & ~sda_out));
    always #2 clk = ~clk;
    always @(posedge clk) tog <= #1 ~tog;
    cocr_smb_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    // id values arbitrary
    cocr_top #(.REV_CODE(4'hA), .VENDOR_CODE(4'h6)) u_dut (
        .clk(clk), .reset(reset), .smb_scl(scl), .smb_sda_in(sda),
        .smb_sda_out(sda_out), .smb_sda_oe(sda_oe), .bus_stop_n(stop_n),
        .bus_src({7{tog}}), .free_src({3{tog}}), .display_48m_src(tog),
        .usb_48m_src(tog), .sixtysix_src(tog), .video_channel_src(tog),
        .sixtysix5_src(tog), .buffered_src({3{tog}}), .bus_clk_out(bus_o),
        .free_clk_out(free_o), .display_48m_clock(dot_o), .usb_48m_clock(usb_o),
        .sixtysix_mhz_output(s66_o), .video_channel_clock(vch_o),
        .sixtysix_mhz_output5(s665_o), .buffered_sixtysix_output(buf_o),
        .buf_delay_ctl(dly), .display_edge_ctl(ed_d), .usb_edge_ctl(ed_u),
        .vendor_revision_id(id));
    task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    task automatic do_reset;
        reset = 1'b1;
        rg = '{8'h7F, 8'hC7, 8'h3F, 8'h00};
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
    endtask : do_reset
    // ==========================================
    // any pulse seen over six cycles means enabled
    task automatic chk_outs;
        logic [17:0] seen, exp;
        seen = '0;
        // a pulse already launched before the change may still finish
        repeat (2) @(posedge clk);
        repeat (6) begin
            @(posedge clk);
            #1 seen |= {bus_o, free_o, dot_o, usb_o, s66_o, vch_o, s665_o, buf_o};
        end
        exp = {rg[2][6:0] & {7{stop_n}}, rg[3][2:0] & ~(rg[3][5:3] & {3{~stop_n}}),
               rg[3][7:6], rg[4][5:0]};
        check("outputs", 40'(seen), 40'(exp));
        check("controls", 40'({dly, ed_d, ed_u}), 40'(rg[5][5:0]));
        check("id", 40'(id), 40'hA6);
    endtask : chk_outs
    // model of acceptance; refused bytes change nothing
    task automatic xfer(input logic [7:0] b[$]);
        logic a, ok;
        logic [39:0] am, ex;
        am = '0;
        ex = '0;
        ok = 1'b1;
        u_host.start();
        foreach (b[i]) begin
            u_host.put_byte(b[i], a);
            am[i] = a;
            if (i == 0) ok = (b[0] == 8'hD2);
            if (i == 1) ok &= (b[1] == 8'h00);
            if (i == 2) ok &= (b[2] >= 8'h01 && b[2] <= 8'h20);
            if (i > 2) ok &= (i - 3 < b[2]);
            ex[i] = ok;
            if (ok && i >= 5 && i <= 8) rg[i-3] = b[i] & wm[i-3];
        end
        u_host.stop();
        check("acks", am, ex);
        chk_outs();
    endtask : xfer
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        do_reset();
        chk_outs();
        // pin used as output, so bit 3 may clear
        xfer('{8'hD2, 8'h00, 8'h06, 8'h11, 8'h22, 8'hAA, 8'h5F, 8'h96, 8'hFF});
        stop_n = 1'b0;
        chk_outs();
        stop_n = 1'b1;
        // refused address, read, command and counts, then bytes past the count, a short write and reserved-bit writes
        xfer('{8'hD4, 8'h00, 8'h01, 8'h00});
        xfer('{8'hD3, 8'h00, 8'h01, 8'h00});
        xfer('{8'hD2, 8'h01, 8'h01, 8'h00});
        xfer('{8'hD2, 8'h00, 8'h00, 8'h00});
        xfer('{8'hD2, 8'h00, 8'h21, 8'h00});
        xfer('{8'hD2, 8'h00, 8'h03, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00});
        xfer('{8'hD2, 8'h00, 8'h06, 8'h00, 8'h00, 8'h01, 8'h07});
        xfer('{8'hD2, 8'h00, 8'h07, 8'h0, 8'h0, 8'h7F, 8'hC7, 8'h3F, 8'h2D, 8'h00});
        xfer('{8'hD2, 8'h00, 8'h05, 8'h0, 8'h0, 8'h80, 8'h38, 8'hC0});
        do_reset();
        chk_outs();
        end_of_test();
    end
endmodule : testbench
